// *** logic/bfc_map.vh ***
// Register map, field positions and reset values of the bulky path controller.
// Assumes byte addresses on a 9-bit register port with 32-bit data.
`ifndef BFC_MAP_VH
`define BFC_MAP_VH

// Register byte addresses.
`define BFC_ADDR_PATH_CTRL 9'h0E8
`define BFC_ADDR_DV_CTRL 9'h0F0
`define BFC_ADDR_INT_STATUS 9'h0F4
`define BFC_ADDR_INT_MASK 9'h0F8
`define BFC_ADDR_HDR_BASE 9'h100
`define BFC_ADDR_HDR_LAST 9'h10C

// Bulky path control fields.
`define BFC_PC_HDR_STRIP 27
`define BFC_PC_RX_DEST 28
`define BFC_PC_TX_SRC 29
`define BFC_PC_RX_FLUSH 30
`define BFC_PC_TX_FLUSH 31

// DV formatter control fields.
`define BFC_DV_RX_EN 0
`define BFC_DV_TX_EN 1
`define BFC_DV_EMPTY_INS 2
`define BFC_DV_H0_INS 3
`define BFC_DV_THR_LO 8
`define BFC_DV_THR_HI 9
`define BFC_DV_MODE_LO 18
`define BFC_DV_MODE_HI 19
`define BFC_DV_MODE_DV 2'h0

// Interrupt status and mask fields.
`define BFC_INT_DBC_ERR 0
`define BFC_INT_DBC_LIMIT 1
`define BFC_INT_HDR_SAVED 2
`define BFC_INT_WIDTH 3

// Reset values.
`define BFC_RST_PATH_CTRL 32'h0000_0000
`define BFC_RST_EMPTY_INS 1'b1
`define BFC_RST_H0_INS 1'b1
`define BFC_RST_THR 2'h0
`define BFC_RST_MODE 2'h0
`define BFC_RST_INT_MASK 3'h0

`endif

// *** logic/bfc_ctrl.v ***
// Bulky FIFO path routing, flush control and DV formatter control for a link controller.
// Assumes all inputs come from logic on sys_clk and the FIFOs themselves sit outside.
// Assumes the FIFOs act on the one-cycle flush and pop pulses that the block hands them.
// Operation
// - With header strip on, received async header quadlets go to header registers only.
// - With receive destination 0, host reads pop the async receive FIFO and nothing goes out on bulky.
// - With receive destination 1, packets go to the bulky interface and host reads are ignored.
// - With transmit source 0, only host writes fill the async transmit FIFO.
// - With transmit source 1, only bulky interface writes fill the async transmit FIFO.
// - Writing one to the receive flush bit empties the async receive FIFO and the bit self clears.
// - Writing one to the transmit flush bit empties the async transmit FIFO and the bit self clears.
// - The DV formatter control register sits at 0F0h and clears on reset except where noted.
// - The bulky receive FIFO takes packets only while receive enable is set.
// - The bulky transmit FIFO sends packets only while transmit enable is set.
// - In DV mode with empty insert set, empty packets spread evenly over a frame, reset value one.
// - In DV mode with H0 insert set, hardware inserts the H0 block, reset value one.
// - With threshold zero a block count mismatch raises an interrupt and reception goes on.
// - With a nonzero threshold each mismatch interrupts and reaching it flushes and rejects.
// - After rejecting, reception resumes only at the next time-stamped packet or on leaving DV mode.
// - DV mode is selected by the two mode bits holding zero.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "bfc_map.vh"

module bfc_ctrl #(
  parameter PKTS_PER_FRAME = 300,
  parameter EMPTY_PER_FRAME = 50,
  parameter ACC_W = 10
) (
  // Clock and reset.
  input wire sys_clk,
  input wire rst_n,
  // Register port.
  input wire [8:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_q,
  output reg irq_q,
  // Async receive stream from the link.
  input wire arx_in_valid,
  input wire arx_in_sop,
  input wire arx_in_hdr,
  input wire [31:0] arx_in_data,
  output reg arx_fifo_wr_q,
  output reg [31:0] arx_fifo_wdata_q,
  // Async receive FIFO drain.
  input wire host_arx_rd,
  input wire bulky_data_interface_arx_rd,
  output reg arx_fifo_pop_q,
  output reg arx_to_bulky_data_interface_q,
  output reg arx_flush_q,
  // Async transmit FIFO fill.
  input wire host_atx_wr,
  input wire [31:0] host_atx_data,
  input wire bulky_data_interface_atx_wr,
  input wire [31:0] bulky_data_interface_atx_data,
  output reg atx_fifo_wr_q,
  output reg [31:0] atx_fifo_wdata_q,
  output reg atx_flush_q,
  // DV receive packet events.
  input wire dv_rx_pkt,
  input wire dv_rx_ts,
  input wire [7:0] dv_rx_dbc,
  input wire [7:0] dv_rx_nblk,
  output reg dv_rx_accept_q,
  output reg dv_rx_flush_q,
  // DV transmit timing.
  input wire cycle_tick,
  input wire frame_start,
  output reg dv_tx_send_en_q,
  output reg dv_tx_empty_q,
  output reg dv_h0_ins_q
);

  reg [31:0] path_ctrl_q;
  reg rx_en_q;
  reg tx_en_q;
  reg empty_ins_q;
  reg h0_ins_q;
  reg [1:0] thr_q;
  reg [1:0] mode_q;
  reg [`BFC_INT_WIDTH-1:0] int_stat_q;
  reg [`BFC_INT_WIDTH-1:0] int_mask_q;
  reg [31:0] hdr_mem [0:3];
  reg [1:0] hdr_idx_q;
  reg [1:0] err_cnt_q;
  reg rejecting_q;
  reg [7:0] exp_dbc_q;
  reg exp_valid_q;
  reg [ACC_W-1:0] acc_q;
  reg [31:0] rdata_d;
  reg [`BFC_INT_WIDTH-1:0] int_set;
  reg dbc_flush;
  reg [ACC_W:0] acc_sum;

  // Only the DV code enables block counting, empty slots and H0 insertion.
  wire dv_mode = (mode_q == `BFC_DV_MODE_DV);
  wire hdr_strip = path_ctrl_q[`BFC_PC_HDR_STRIP];
  wire rx_dest = path_ctrl_q[`BFC_PC_RX_DEST];
  wire tx_src = path_ctrl_q[`BFC_PC_TX_SRC];
  wire wr_path = reg_wr && (reg_addr == `BFC_ADDR_PATH_CTRL);
  wire wr_dv = reg_wr && (reg_addr == `BFC_ADDR_DV_CTRL);
  wire wr_stat = reg_wr && (reg_addr == `BFC_ADDR_INT_STATUS);
  wire wr_mask = reg_wr && (reg_addr == `BFC_ADDR_INT_MASK);
  wire hdr_take = arx_in_valid && arx_in_hdr && hdr_strip;
  wire pkt_seen = dv_rx_pkt && dv_mode && rx_en_q;
  wire mismatch = pkt_seen && !rejecting_q && exp_valid_q && (dv_rx_dbc != exp_dbc_q);
  wire [1:0] err_next = err_cnt_q + 2'h1;
  // The parameters are cut to ACC_W+1 bits, one above the accumulator width, on purpose; the defaults fit.
  wire [ACC_W:0] empty_w = EMPTY_PER_FRAME[ACC_W:0];
  wire [ACC_W:0] pkts_w = PKTS_PER_FRAME[ACC_W:0];
  // Outside DV mode there is no block count, so nothing is ever turned away.
  wire rx_block = dv_mode && ((rejecting_q && !dv_rx_ts) || dbc_flush);

  // Path and formatter control registers.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      path_ctrl_q <= `BFC_RST_PATH_CTRL;
      rx_en_q <= 1'b0;
      tx_en_q <= 1'b0;
      empty_ins_q <= `BFC_RST_EMPTY_INS;
      h0_ins_q <= `BFC_RST_H0_INS;
      thr_q <= `BFC_RST_THR;
      mode_q <= `BFC_RST_MODE;
      int_mask_q <= `BFC_RST_INT_MASK;
    end else begin
      // Bits below the header strip field are stored but read back as zero.
      if (wr_path) begin
        path_ctrl_q <= reg_wdata;
      end else begin
        // Flush bits live only for the cycle after the write.
        path_ctrl_q[`BFC_PC_RX_FLUSH] <= 1'b0;
        path_ctrl_q[`BFC_PC_TX_FLUSH] <= 1'b0;
      end
      // Reserved bits of the DV formatter register read zero and ignore writes.
      if (wr_dv) begin
        rx_en_q <= reg_wdata[`BFC_DV_RX_EN];
        tx_en_q <= reg_wdata[`BFC_DV_TX_EN];
        empty_ins_q <= reg_wdata[`BFC_DV_EMPTY_INS];
        h0_ins_q <= reg_wdata[`BFC_DV_H0_INS];
        thr_q <= reg_wdata[`BFC_DV_THR_HI:`BFC_DV_THR_LO];
        mode_q <= reg_wdata[`BFC_DV_MODE_HI:`BFC_DV_MODE_LO];
      end
      if (wr_mask) begin
        int_mask_q <= reg_wdata[`BFC_INT_WIDTH-1:0];
      end
    end
  end

  // Read data, one cycle after the strobe; unmapped addresses read zero.
  // The read port never stalls the master, and the data stand for one cycle only.
  always @* begin
    rdata_d = 32'h0000_0000;
    case (reg_addr)
      `BFC_ADDR_PATH_CTRL: begin
        rdata_d = path_ctrl_q;
        rdata_d[`BFC_PC_RX_FLUSH] = 1'b0;
        rdata_d[`BFC_PC_TX_FLUSH] = 1'b0;
        rdata_d[26:0] = 27'h0;
      end
      `BFC_ADDR_DV_CTRL: begin
        rdata_d[`BFC_DV_RX_EN] = rx_en_q;
        rdata_d[`BFC_DV_TX_EN] = tx_en_q;
        rdata_d[`BFC_DV_EMPTY_INS] = empty_ins_q;
        rdata_d[`BFC_DV_H0_INS] = h0_ins_q;
        rdata_d[`BFC_DV_THR_HI:`BFC_DV_THR_LO] = thr_q;
        rdata_d[`BFC_DV_MODE_HI:`BFC_DV_MODE_LO] = mode_q;
      end
      `BFC_ADDR_INT_STATUS: begin
        rdata_d[`BFC_INT_WIDTH-1:0] = int_stat_q;
      end
      `BFC_ADDR_INT_MASK: begin
        rdata_d[`BFC_INT_WIDTH-1:0] = int_mask_q;
      end
      // Header registers are read only; writes to them match no register.
      default: begin
        if (reg_addr >= `BFC_ADDR_HDR_BASE && reg_addr <= `BFC_ADDR_HDR_LAST) begin
          rdata_d = hdr_mem[reg_addr[3:2]];
        end
      end
    endcase
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata_q <= rdata_d;
    end else begin
      reg_rdata_q <= 32'h0000_0000;
    end
  end

  // Header capture; the array has no reset, software reads it only after a capture.
  always @(posedge sys_clk) begin
    if (hdr_take) begin
      hdr_mem[arx_in_sop ? 2'h0 : hdr_idx_q] <= arx_in_data;
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hdr_idx_q <= 2'h0;
    end else if (hdr_take) begin
      // A fifth header quadlet wraps onto the first register.
      hdr_idx_q <= (arx_in_sop ? 2'h0 : hdr_idx_q) + 2'h1;
    end else if (arx_in_valid) begin
      hdr_idx_q <= 2'h0;
    end
  end

  // Async receive and transmit routing.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      arx_fifo_wr_q <= 1'b0;
      arx_fifo_wdata_q <= 32'h0000_0000;
      arx_fifo_pop_q <= 1'b0;
      arx_to_bulky_data_interface_q <= 1'b0;
      arx_flush_q <= 1'b0;
      atx_fifo_wr_q <= 1'b0;
      atx_fifo_wdata_q <= 32'h0000_0000;
      atx_flush_q <= 1'b0;
    end else begin
      // Stripped header quadlets never reach the FIFO.
      arx_fifo_wr_q <= arx_in_valid && !hdr_take;
      arx_fifo_wdata_q <= arx_in_data;
      arx_to_bulky_data_interface_q <= rx_dest;
      // Only the owner selected by the destination bit may pop.
      if (rx_dest) begin
        arx_fifo_pop_q <= bulky_data_interface_arx_rd;
      end else begin
        arx_fifo_pop_q <= host_arx_rd;
      end
      // A flush reaches the FIFO as a one-cycle pulse, never as a level.
      arx_flush_q <= wr_path && reg_wdata[`BFC_PC_RX_FLUSH];
      atx_flush_q <= wr_path && reg_wdata[`BFC_PC_TX_FLUSH];
      // Writes from the source that does not own the FIFO are dropped without notice.
      if (tx_src) begin
        atx_fifo_wr_q <= bulky_data_interface_atx_wr;
        atx_fifo_wdata_q <= bulky_data_interface_atx_data;
      end else begin
        atx_fifo_wr_q <= host_atx_wr;
        atx_fifo_wdata_q <= host_atx_data;
      end
    end
  end

  // Block count checking on DV receive packets.
  always @* begin
    dbc_flush = mismatch && (thr_q != 2'h0) && (err_next == thr_q);
    int_set = {`BFC_INT_WIDTH{1'b0}};
    int_set[`BFC_INT_DBC_ERR] = mismatch;
    int_set[`BFC_INT_DBC_LIMIT] = dbc_flush;
    int_set[`BFC_INT_HDR_SAVED] = hdr_take;
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_cnt_q <= 2'h0;
      rejecting_q <= 1'b0;
      exp_dbc_q <= 8'h00;
      exp_valid_q <= 1'b0;
      dv_rx_accept_q <= 1'b0;
      dv_rx_flush_q <= 1'b0;
    end else begin
      dv_rx_flush_q <= dbc_flush;
      // Packets count only while receive is enabled.
      dv_rx_accept_q <= dv_rx_pkt && rx_en_q && !rx_block;
      if (pkt_seen) begin
        exp_dbc_q <= dv_rx_dbc + dv_rx_nblk;
        exp_valid_q <= 1'b1;
      end
      if (wr_dv) begin
        err_cnt_q <= 2'h0;
      end else if (pkt_seen && rejecting_q && dv_rx_ts) begin
        err_cnt_q <= 2'h0;
      end else if (mismatch && thr_q != 2'h0) begin
        // The count restarts at the limit too, so a later run of errors trips it afresh.
        err_cnt_q <= dbc_flush ? 2'h0 : err_next;
      end
      if (dbc_flush) begin
        rejecting_q <= 1'b1;
      end else if (pkt_seen && dv_rx_ts) begin
        rejecting_q <= 1'b0;
      end else if (!dv_mode) begin
        rejecting_q <= 1'b0;
      end
    end
  end

  // Interrupt status: a hardware set wins over a write-one clear in the same cycle.
  // Bits written as zero are left untouched by a status write.
  // The pin lags the status by one cycle so that it comes straight off a flop.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_stat_q <= {`BFC_INT_WIDTH{1'b0}};
      irq_q <= 1'b0;
    end else begin
      int_stat_q <= (int_stat_q & ~(wr_stat ? reg_wdata[`BFC_INT_WIDTH-1:0] :
        {`BFC_INT_WIDTH{1'b0}})) | int_set;
      irq_q <= |(int_stat_q & int_mask_q);
    end
  end

  // Transmit controls and empty packet spreading.
  // The remainder stays below PKTS_PER_FRAME, which must therefore fit in ACC_W bits.
  always @* begin
    acc_sum = {1'b0, acc_q} + empty_w;
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= {ACC_W{1'b0}};
      dv_tx_empty_q <= 1'b0;
      dv_tx_send_en_q <= 1'b0;
      dv_h0_ins_q <= 1'b0;
    end else begin
      dv_tx_send_en_q <= tx_en_q;
      dv_h0_ins_q <= dv_mode && h0_ins_q;
      dv_tx_empty_q <= 1'b0;
      // A running remainder spaces the empty slots evenly; frame start realigns it.
      // Slots pass uncounted while transmit is off, so a paused stream keeps its phase.
      if (frame_start) begin
        acc_q <= {ACC_W{1'b0}};
      end else if (cycle_tick && dv_mode && empty_ins_q && tx_en_q) begin
        if (acc_sum >= pkts_w) begin
          acc_q <= acc_sum[ACC_W-1:0] - pkts_w[ACC_W-1:0];
          dv_tx_empty_q <= 1'b1;
        end else begin
          acc_q <= acc_sum[ACC_W-1:0];
        end
      end
    end
  end

endmodule

`default_nettype wire

// *** testbench/bfc_ctrl_properties.sv ***
// Port checker for the bulky path controller.
// Assumes it is bound onto bfc_ctrl with one clock and rst_n active low.
`timescale 1ns/10ps
`default_nettype none
`include "bfc_map.vh"
module bfc_ctrl_chk (
  // Clock, reset and register writes.
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [8:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  // Async FIFO paths.
  input wire logic arx_in_valid,
  input wire logic arx_fifo_wr_q,
  input wire logic host_arx_rd,
  input wire logic bulky_data_interface_arx_rd,
  input wire logic arx_fifo_pop_q,
  input wire logic arx_to_bulky_data_interface_q,
  input wire logic arx_flush_q,
  input wire logic atx_flush_q,
  // DV events.
  input wire logic dv_rx_pkt,
  input wire logic dv_rx_accept_q,
  input wire logic dv_rx_flush_q,
  input wire logic cycle_tick,
  input wire logic dv_tx_empty_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire wr_pc = reg_wr && reg_addr == `BFC_ADDR_PATH_CTRL;
  chk_rx_flush_set: assert property (
    wr_pc && reg_wdata[30] |=> arx_flush_q ##1 !arx_flush_q) else $error("rx flush pulse");
  chk_tx_flush_set: assert property (
    wr_pc && reg_wdata[31] |=> atx_flush_q ##1 !atx_flush_q) else $error("tx flush pulse");
  chk_rx_flush_only: assert property (
    arx_flush_q |-> $past(wr_pc) && $past(reg_wdata[30])) else $error("stray rx flush");
  // Two samples of the select make the check blind to when the bit settles.
  chk_pop_app: assert property (
    (!bulky_data_interface_arx_rd && arx_to_bulky_data_interface_q) ##1 arx_to_bulky_data_interface_q |-> !arx_fifo_pop_q)
    else $error("host pop in app mode");
  chk_pop_host: assert property (
    (host_arx_rd && !arx_to_bulky_data_interface_q) ##1 !arx_to_bulky_data_interface_q |-> arx_fifo_pop_q)
    else $error("host pop lost");
  chk_rej_flush: assert property (
    dv_rx_flush_q |-> !dv_rx_accept_q && $past(dv_rx_pkt)) else $error("flush with accept");
  chk_accept_cause: assert property (
    dv_rx_accept_q |-> $past(dv_rx_pkt)) else $error("accept without packet");
  chk_empty_cause: assert property (
    dv_tx_empty_q |-> $past(cycle_tick)) else $error("empty without slot");
  chk_rx_wr_cause: assert property (
    arx_fifo_wr_q |-> $past(arx_in_valid)) else $error("rx write without word");
  cover property (dv_rx_flush_q);
  cover property (dv_tx_empty_q);
  cover property (arx_to_bulky_data_interface_q && arx_fifo_pop_q);
endmodule
bind bfc_ctrl bfc_ctrl_chk u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .arx_in_valid(arx_in_valid), .arx_fifo_wr_q(arx_fifo_wr_q),
  .host_arx_rd(host_arx_rd), .bulky_data_interface_arx_rd(bulky_data_interface_arx_rd), .arx_fifo_pop_q(arx_fifo_pop_q),
  .arx_to_bulky_data_interface_q(arx_to_bulky_data_interface_q), .arx_flush_q(arx_flush_q), .atx_flush_q(atx_flush_q),
  .dv_rx_pkt(dv_rx_pkt), .dv_rx_accept_q(dv_rx_accept_q), .dv_rx_flush_q(dv_rx_flush_q),
  .cycle_tick(cycle_tick), .dv_tx_empty_q(dv_tx_empty_q)
);
`default_nettype wire

// *** testbench/bfc_app_model.sv ***
// Application on the bulky interface.
// Assumes the bench changes requests just after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module bfc_app_model (
  // Requests from the bench.
  input wire rd_req,
  input wire wr_req,
  input wire [31:0] wr_word,
  // Bulky interface.
  output logic bulky_data_interface_arx_rd,
  output logic bulky_data_interface_atx_wr,
  output logic [31:0] bulky_data_interface_atx_data
);
  // Idle data is inverted so a stale word never passes for a write.
  assign bulky_data_interface_arx_rd = rd_req;
  assign bulky_data_interface_atx_wr = wr_req;
  assign bulky_data_interface_atx_data = wr_req ? wr_word : ~wr_word;
endmodule
`default_nettype wire

// *** testbench/bfc_ctrl_tb.sv ***
// Self-checking bench for the bulky path controller.
// Assumes the design, checker and application model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "bfc_map.vh"
module bfc_ctrl_tb;
  logic sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, arx_in_valid = 0, arx_in_sop = 0;
  logic arx_in_hdr = 0, host_arx_rd = 0, host_atx_wr = 0, dv_rx_pkt = 0, dv_rx_ts = 0;
  logic cycle_tick = 0, frame_start = 0, rd_req = 0, wr_req = 0;
  logic [8:0] reg_addr = 0;
  logic [7:0] dv_rx_dbc = 0, dv_rx_nblk = 0;
  logic [31:0] reg_wdata = 0, arx_in_data = 0, host_atx_data = 0, wr_word = 0, lfsr = 32'h93DA;
  logic irq_q, arx_fifo_wr_q, arx_fifo_pop_q, arx_to_bulky_data_interface_q, arx_flush_q, atx_fifo_wr_q;
  logic atx_flush_q, dv_rx_accept_q, dv_rx_flush_q, dv_tx_send_en_q, dv_tx_empty_q;
  logic dv_h0_ins_q, bulky_data_interface_arx_rd, bulky_data_interface_atx_wr;
  logic [31:0] reg_rdata_q, arx_fifo_wdata_q, atx_fifo_wdata_q, bulky_data_interface_atx_data;
  int n_fail = 0, checks = 0, cyc = 0, n_empty = 0;
  bfc_ctrl u_bfc_ctrl (.*);
  bfc_app_model u_bfc_app_model (.*);
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (dv_tx_empty_q === 1'b1) n_empty <= n_empty + 1;
    if (cyc == 5000) begin
      n_fail++;
      summarize;
    end
  end
  function automatic logic [31:0] step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge sys_clk);
    reg_wr <= 0;
    #1;
  endtask
  task automatic rd(input logic [8:0] a, input logic [31:0] e, input string nm);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge sys_clk);
    reg_rd <= 0;
    #1 chk(nm, reg_rdata_q, e);
  endtask
  task automatic pkt(input logic ts, input logic [7:0] d, input logic a, input logic f);
    @(posedge sys_clk);
    {dv_rx_pkt, dv_rx_ts, dv_rx_dbc, dv_rx_nblk} <= {1'b1, ts, d, 8'h04};
    @(posedge sys_clk);
    dv_rx_pkt <= 0;
    #1 chk("accept", dv_rx_accept_q, a);
    chk("rx flush", dv_rx_flush_q, f);
  endtask
  task automatic ticks(input int n, input int e);
    int s;
    s = n_empty;
    repeat (n) begin
      @(posedge sys_clk);
      cycle_tick <= 1;
      @(posedge sys_clk);
      cycle_tick <= 0;
    end
    repeat (2) @(posedge sys_clk);
    #1 chk("empties", n_empty - s, e);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1;
    rd(`BFC_ADDR_DV_CTRL, 32'h0000_000C, "dv reset");
    rd(`BFC_ADDR_PATH_CTRL, 32'h0, "path reset");
    rd(9'h1F0, 32'h0, "unmapped");
    chk("h0", dv_h0_ins_q, 32'h1);
    for (int i = 0; i < 2; i++) begin
      wr(`BFC_ADDR_PATH_CTRL, 32'h4000_0000 << i);
      chk("flush", {arx_flush_q, atx_flush_q}, i ? 2'h1 : 2'h2);
      @(posedge sys_clk);
      #1 chk("flush end", {arx_flush_q, atx_flush_q}, 32'h0);
      rd(`BFC_ADDR_PATH_CTRL, 32'h0, "flush bits");
    end
    $display("test flush done");
    for (int i = 0; i < 16; i++) begin
      lfsr = step(lfsr);
      wr(`BFC_ADDR_PATH_CTRL, {2'h0, lfsr[1:0], 28'h0});
      @(posedge sys_clk);
      {host_arx_rd, rd_req, host_atx_wr, wr_req} <= lfsr[5:2];
      host_atx_data <= lfsr;
      wr_word <= {lfsr[15:0], lfsr[31:16]};
      @(posedge sys_clk);
      {host_arx_rd, rd_req, host_atx_wr, wr_req} <= 4'h0;
      #1 chk("dest", arx_to_bulky_data_interface_q, lfsr[0]);
      chk("pop", arx_fifo_pop_q, lfsr[0] ? lfsr[4] : lfsr[5]);
      chk("tx wr", atx_fifo_wr_q, lfsr[1] ? lfsr[2] : lfsr[3]);
      if (atx_fifo_wr_q === 1'b1)
        chk("tx data", atx_fifo_wdata_q, lfsr[1] ? wr_word : lfsr);
    end
    $display("test routing done");
    wr(`BFC_ADDR_PATH_CTRL, 32'h0800_0000);
    @(posedge sys_clk);
    {arx_in_valid, arx_in_sop, arx_in_hdr, arx_in_data} <= {3'h7, 32'hCAFE_0001};
    @(posedge sys_clk);
    {arx_in_sop, arx_in_hdr, arx_in_data} <= {2'h0, 32'h1234_5678};
    #1 chk("hdr wr", arx_fifo_wr_q, 32'h0);
    @(posedge sys_clk);
    arx_in_valid <= 0;
    #1 chk("data wr", arx_fifo_wr_q, 32'h1);
    chk("data", arx_fifo_wdata_q, 32'h1234_5678);
    rd(`BFC_ADDR_HDR_BASE, 32'hCAFE_0001, "hdr reg");
    wr(`BFC_ADDR_INT_MASK, 32'h4);
    @(posedge sys_clk);
    #1 chk("irq on", irq_q, 32'h1);
    wr(`BFC_ADDR_INT_STATUS, 32'h4);
    @(posedge sys_clk);
    #1 chk("irq clear", irq_q, 32'h0);
    wr(`BFC_ADDR_INT_MASK, 32'h0);
    $display("test header done");
    pkt(1'b0, 8'h00, 1'b0, 1'b0);
    wr(`BFC_ADDR_DV_CTRL, 32'h0000_000D);
    pkt(1'b0, 8'h04, 1'b1, 1'b0);
    pkt(1'b0, 8'h0B, 1'b1, 1'b0);
    rd(`BFC_ADDR_INT_STATUS, 32'h1, "dbc err");
    chk("irq masked", irq_q, 32'h0);
    wr(`BFC_ADDR_INT_STATUS, 32'h3);
    wr(`BFC_ADDR_DV_CTRL, 32'h0000_020D);
    pkt(1'b0, 8'h0F, 1'b1, 1'b0);
    pkt(1'b0, 8'h20, 1'b1, 1'b0);
    pkt(1'b0, 8'h30, 1'b0, 1'b1);
    pkt(1'b0, 8'h34, 1'b0, 1'b0);
    pkt(1'b1, 8'h38, 1'b1, 1'b0);
    pkt(1'b0, 8'h00, 1'b1, 1'b0);
    wr(`BFC_ADDR_DV_CTRL, 32'h0000_020D);
    pkt(1'b0, 8'h11, 1'b1, 1'b0);
    rd(`BFC_ADDR_INT_STATUS, 32'h3, "dbc limit");
    $display("test dv receive done");
    wr(`BFC_ADDR_DV_CTRL, 32'h0000_000C);
    ticks(6, 0);
    chk("send off", dv_tx_send_en_q, 32'h0);
    wr(`BFC_ADDR_DV_CTRL, 32'h0000_000E);
    ticks(12, 2);
    chk("send on", dv_tx_send_en_q, 32'h1);
    wr(`BFC_ADDR_DV_CTRL, 32'h0000_000A);
    ticks(12, 0);
    wr(`BFC_ADDR_DV_CTRL, 32'h0004_000E);
    ticks(12, 0);
    chk("h0 mode", dv_h0_ins_q, 32'h0);
    wr(`BFC_ADDR_DV_CTRL, 32'h0000_000E);
    ticks(4, 0);
    @(posedge sys_clk);
    frame_start <= 1;
    @(posedge sys_clk);
    frame_start <= 0;
    ticks(4, 0);
    ticks(2, 1);
    $display("test dv transmit done");
    summarize;
  end
endmodule
`default_nettype wire
